// ### hw/tmz_timer.sv
// Timer/counter with shared prescaler, watchdog postscaler and APB slave
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module tmz_timer #(
    parameter int WDT_TICK_DIV = 180
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic EXT_COUNT_PIN,
    output logic IRQ,
    output logic WDT_RESET
);
    // ****************
    // Helpers
    // ****************
    function automatic logic reg_hit(input logic [31:0] a,
                                     input logic [7:0] idx);
        reg_hit = (a[31:2] == {22'h00_0000, idx});
    endfunction

    // Tap of the prescaler for a division of 2^k, k in 0..8
    function automatic logic ps_tap(input logic [7:0] cnt,
                                    input logic [7:0] nxt, input int k);
        logic r;
        r = 1'b1;
        if (k > 0) begin
            r = cnt[k-1] & ~nxt[k-1];
        end
        ps_tap = r;
    endfunction

    logic [7:0] tmr_q, intc_q, opt_q, port_a_direction_q, ctl_q;
    logic [1:0] irq_sts_q, irq_mask_q;
    logic [7:0] ps_q;
    logic [7:0] wdt_q;
    logic [15:0] wdt_div_q;
    logic [1:0] inhibit_q;
    logic sync1_q, sync2_q;
    logic [1:0] apb_st;

    // ****************
    // APB decode
    // ****************
    logic wr, rd_en, mapped;
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & PENABLE & ~PWRITE;
    assign PREADY = 1'b1;
    assign mapped = reg_hit(PADDR, tmz_pkg::IDX_TIMER_COUNT)
        | reg_hit(PADDR, tmz_pkg::IDX_INTERRUPT_CONTROL)
        | reg_hit(PADDR, tmz_pkg::IDX_OPTION_SETTINGS)
        | reg_hit(PADDR, tmz_pkg::IDX_PORT_A_DIRECTION)
        | reg_hit(PADDR, tmz_pkg::IDX_IRQ_STATUS)
        | reg_hit(PADDR, tmz_pkg::IDX_IRQ_MASK)
        | reg_hit(PADDR, tmz_pkg::IDX_CONTROL)
        | reg_hit(PADDR, tmz_pkg::IDX_WDT_COUNT);
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign apb_st = 2'h0;

    logic wr_tmr, wr_intc, wr_opt, wr_port_a_direction, wr_sts, wr_mask, wr_ctl;
    assign wr_tmr = wr & reg_hit(PADDR, tmz_pkg::IDX_TIMER_COUNT);
    assign wr_intc = wr & reg_hit(PADDR, tmz_pkg::IDX_INTERRUPT_CONTROL);
    assign wr_opt = wr & reg_hit(PADDR, tmz_pkg::IDX_OPTION_SETTINGS);
    assign wr_port_a_direction = wr & reg_hit(PADDR, tmz_pkg::IDX_PORT_A_DIRECTION);
    assign wr_sts = wr & reg_hit(PADDR, tmz_pkg::IDX_IRQ_STATUS);
    assign wr_mask = wr & reg_hit(PADDR, tmz_pkg::IDX_IRQ_MASK);
    assign wr_ctl = wr & reg_hit(PADDR, tmz_pkg::IDX_CONTROL);

    // ****************
    // Option fields
    // ****************
    logic src_sel, edge_sel, assign_wdt, sleeping, wdt_en, wdt_clear;
    logic [2:0] ratio;
    assign src_sel = opt_q[tmz_pkg::OPT_CLOCK_SOURCE_SELECT];
    assign edge_sel = opt_q[tmz_pkg::OPT_SOURCE_EDGE_SELECT];
    assign assign_wdt = opt_q[tmz_pkg::OPT_PRESCALER_ASSIGN];
    assign ratio = opt_q[tmz_pkg::OPT_RATIO_HI:0];
    assign sleeping = ctl_q[tmz_pkg::CTL_SLEEP];
    assign wdt_en = ctl_q[tmz_pkg::CTL_WDT_EN];
    // Watchdog clear instruction is a self-clearing write of this bit
    assign wdt_clear = wr_ctl & PWDATA[tmz_pkg::CTL_WDT_CLEAR];

    // ****************
    // External clock path
    // ****************
    // Pin synchroniser, then edge detect on the second stage
    logic sync_a_q, sync_b_q, pin_d1_q;
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            sync_a_q <= 1'b0;
            sync_b_q <= 1'b0;
            pin_d1_q <= 1'b0;
        end else begin
            sync_a_q <= EXT_COUNT_PIN;
            sync_b_q <= sync_a_q;
            pin_d1_q <= sync_b_q;
        end
    end

    logic ext_edge;
    assign ext_edge = edge_sel ? (pin_d1_q & ~sync_b_q)
                               : (~pin_d1_q & sync_b_q);

    // Source before prescaler: cycle tick or selected pin edge
    logic src_tick;
    assign src_tick = src_sel ? ext_edge : 1'b1;

    // Watchdog base tick from a free divider
    logic wdt_tick;
    assign wdt_tick = (wdt_div_q == 16'(WDT_TICK_DIV - 1));
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            wdt_div_q <= 16'h0000;
        end else if (wdt_tick) begin
            wdt_div_q <= 16'h0000;
        end else begin
            wdt_div_q <= wdt_div_q + 16'h0001;
        end
    end

    // ****************
    // Shared prescaler
    // ****************
    logic ps_in, ps_out;
    logic [7:0] ps_nxt;
    logic [3:0] ps_k;
    assign ps_in = assign_wdt ? (wdt_tick & wdt_en) : (src_tick & ~sleeping);
    assign ps_nxt = ps_q + 8'h01;
    assign ps_k = assign_wdt ? {1'b0, ratio} : ({1'b0, ratio} + 4'h1);
    assign ps_out = ps_in & ps_tap(ps_q, ps_nxt, int'(ps_k));

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ps_q <= tmz_pkg::RST_ZERO;
        end else if (wr_tmr && !assign_wdt) begin
            ps_q <= tmz_pkg::RST_ZERO;
        end else if (wdt_clear && assign_wdt) begin
            ps_q <= tmz_pkg::RST_ZERO;
        end else if (ps_in) begin
            ps_q <= ps_nxt;
        end
    end

    // Timer tick after optional prescaler
    logic tmr_src;
    assign tmr_src = assign_wdt ? (src_tick & ~sleeping) : ps_out;

    // External ticks cross a further two-stage delay before counting
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= tmr_src & src_sel;
            sync2_q <= sync1_q;
        end
    end
    logic tmr_inc;
    assign tmr_inc = (src_sel ? sync2_q : tmr_src) & ~sleeping
        & (inhibit_q == 2'h0);

    // ****************
    // Counter
    // ****************
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            inhibit_q <= 2'h0;
        end else if (wr_tmr) begin
            inhibit_q <= tmz_pkg::INHIBIT_LOAD;
        end else if (inhibit_q != 2'h0) begin
            inhibit_q <= inhibit_q - 2'h1;
        end
    end

    logic ovf;
    assign ovf = tmr_inc & (tmr_q == tmz_pkg::COUNT_MAX) & ~wr_tmr;

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            tmr_q <= tmz_pkg::RST_ZERO;
        end else if (wr_tmr) begin
            tmr_q <= PWDATA[7:0];
        end else if (tmr_inc) begin
            tmr_q <= tmr_q + 8'h01;
        end
    end

    // ****************
    // Watchdog
    // ****************
    logic wdt_inc;
    assign wdt_inc = assign_wdt ? ps_out : (wdt_tick & wdt_en);
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            wdt_q <= tmz_pkg::RST_ZERO;
            WDT_RESET <= 1'b0;
        end else begin
            WDT_RESET <= wdt_inc & (wdt_q == tmz_pkg::COUNT_MAX)
                & ~wdt_clear;
            if (wdt_clear) begin
                wdt_q <= tmz_pkg::RST_ZERO;
            end else if (wdt_inc) begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    // ****************
    // Registers
    // ****************
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            opt_q <= tmz_pkg::RST_OPTION;
        end else if (wr_opt) begin
            opt_q <= PWDATA[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            port_a_direction_q <= tmz_pkg::RST_PORT_A_DIR;
        end else if (wr_port_a_direction) begin
            port_a_direction_q <= {2'b00, PWDATA[5:0]};
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            ctl_q <= tmz_pkg::RST_ZERO;
        end else if (wr_ctl) begin
            ctl_q <= {6'h00, PWDATA[tmz_pkg::CTL_WDT_EN],
                      PWDATA[tmz_pkg::CTL_SLEEP]};
        end
    end

    // Overflow flag: set wins over a software clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            intc_q <= tmz_pkg::RST_ZERO;
        end else begin
            if (wr_intc) begin
                intc_q <= PWDATA[7:0];
            end
            if (ovf) begin
                intc_q[tmz_pkg::INTC_OVERFLOW_FLAG] <= 1'b1;
            end
        end
    end

    // Sticky status, write one to clear, set wins
    logic [1:0] ev;
    assign ev = {WDT_RESET, ovf};
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            irq_sts_q <= 2'h0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~(wr_sts ? PWDATA[1:0] : 2'h0)) | ev;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            irq_mask_q <= 2'h0;
        end else if (wr_mask) begin
            irq_mask_q <= PWDATA[1:0];
        end
    end

    // Overflow request gated by its enable bit and by the mask
    logic [1:0] req;
    assign req[tmz_pkg::IRQ_OVERFLOW] = irq_sts_q[tmz_pkg::IRQ_OVERFLOW]
        & intc_q[tmz_pkg::INTC_OVERFLOW_ENABLE];
    assign req[tmz_pkg::IRQ_WDT] = irq_sts_q[tmz_pkg::IRQ_WDT];
    assign IRQ = |(req & irq_mask_q);

    // ****************
    // Read data
    // ****************
    logic [7:0] rd;
    always_comb begin
        rd = 8'h00;
        if (reg_hit(PADDR, tmz_pkg::IDX_TIMER_COUNT)) begin
            rd = tmr_q;
        end else if (reg_hit(PADDR, tmz_pkg::IDX_INTERRUPT_CONTROL)) begin
            rd = intc_q;
        end else if (reg_hit(PADDR, tmz_pkg::IDX_OPTION_SETTINGS)) begin
            rd = opt_q;
        end else if (reg_hit(PADDR, tmz_pkg::IDX_PORT_A_DIRECTION)) begin
            rd = port_a_direction_q;
        end else if (reg_hit(PADDR, tmz_pkg::IDX_IRQ_STATUS)) begin
            rd = {6'h00, irq_sts_q};
        end else if (reg_hit(PADDR, tmz_pkg::IDX_IRQ_MASK)) begin
            rd = {6'h00, irq_mask_q};
        end else if (reg_hit(PADDR, tmz_pkg::IDX_CONTROL)) begin
            rd = ctl_q;
        end else if (reg_hit(PADDR, tmz_pkg::IDX_WDT_COUNT)) begin
            rd = wdt_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= {24'h00_0000, rd};
        end
    end
endmodule

// ### hw/tmz_pkg.sv
// Package with register map, field positions and constants of the timer
package tmz_pkg;
    // ****************
    // Register map
    // ****************
    // Printed offsets are not all multiples of four: they are indices
    localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_OPTION_SETTINGS = 8'h81;
    localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
    localparam logic [7:0] IDX_CONTROL = 8'h92;
    localparam logic [7:0] IDX_WDT_COUNT = 8'h93;

    // ****************
    // Reset values
    // ****************
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [7:0] RST_PORT_A_DIR = 8'h3f;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ****************
    // Field positions
    // ****************
    localparam int OPT_CLOCK_SOURCE_SELECT = 5;
    localparam int OPT_SOURCE_EDGE_SELECT = 4;
    localparam int OPT_PRESCALER_ASSIGN = 3;
    localparam int OPT_RATIO_HI = 2;
    localparam int INTC_OVERFLOW_FLAG = 2;
    localparam int INTC_OVERFLOW_ENABLE = 5;
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_WDT = 1;
    localparam int CTL_SLEEP = 0;
    localparam int CTL_WDT_EN = 1;
    localparam int CTL_WDT_CLEAR = 2;
    localparam int PORTA_COUNT_BIT = 4;

    // ****************
    // Timing
    // ****************
    localparam int WRITE_INHIBIT_CYCLES = 2;
    localparam logic [1:0] INHIBIT_LOAD = 2'h2;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    typedef enum logic [2:0] {
        TMZ_IDLE = 3'b001,
        TMZ_SETUP = 3'b010,
        TMZ_ACCESS = 3'b100
    } tmz_apb_t;
endpackage

// ### sim/tmz_timer_assertions.sv
// Checker of the timer's bus and interrupt ports
`timescale 1ns/10ps
module tmz_chk (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic IRQ,
    input wire logic WDT_RESET
);
    logic en_q;
    logic [1:0] mask_q;
    logic acc;
    assign acc = PSEL && PENABLE;
    // Enable bit of interrupt control
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            en_q <= 1'b0;
        end else if (acc && PWRITE && PADDR == 32'h0000_002c) begin
            en_q <= PWDATA[5];
        end
    end
    // Interrupt mask
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            mask_q <= 2'h0;
        end else if (acc && PWRITE && PADDR == 32'h0000_0244) begin
            mask_q <= PWDATA[1:0];
        end
    end
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);
    chk_ready_in_access: assert property (acc |-> PREADY)
        else $error("no ready in access phase");
    chk_err_mapped: assert property (acc && PADDR == 32'h0000_0004 |-> !PSLVERR)
        else $error("error on mapped place");
    chk_err_unmapped: assert property (acc && PADDR == 32'h0000_0140 |-> PSLVERR)
        else $error("no error on unmapped place");
    chk_err_phase: assert property (PSLVERR |-> acc)
        else $error("error outside access phase");
    chk_rdata_upper: assert property (PRDATA[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_err_rdata: assert property (acc && !PWRITE && PSLVERR |->
        PRDATA == 32'h0000_0000) else $error("read data on error");
    chk_wdt_one_pulse: assert property ($rose(WDT_RESET) |=> !WDT_RESET)
        else $error("watchdog reset pulse too long");
    chk_irq_in_reset: assert property (disable iff (1'b0) !NRST |=> !IRQ)
        else $error("interrupt in reset");
    chk_irq_gated: assert property (IRQ |-> (en_q && mask_q[0]) || mask_q[1])
        else $error("interrupt while disabled");
    cover property (acc && PSLVERR);
    cover property ($rose(IRQ));
    cover property (acc && PWRITE && PADDR == 32'h0000_0004);
endmodule
bind tmz_timer tmz_chk i_chk (.MCLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ, .WDT_RESET);

// ### sim/tmz_ext_src.sv
// External count source driving the count pin
`timescale 1ns/10ps
module tmz_ext_src (
    input wire logic MCLK,
    output logic EXT_COUNT_PIN
);
    initial EXT_COUNT_PIN = 1'b0;
    // Level held for n cycles, n at least three
    task automatic hold(input logic lvl, input int n);
        @(posedge MCLK);
        EXT_COUNT_PIN <= lvl;
        repeat (n) @(posedge MCLK);
    endtask
endmodule

// ### sim/test_timer0_with_shared_prescaler.sv
// Self-checking bench of the timer with shared prescaler
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin \
    num_errors++; $display("[FAIL] %0t got %h want %h", $time, a, e); \
    end end
module test_timer0_with_shared_prescaler;
    typedef struct {logic [7:0] v; logic f;} tmz_row_t;
    logic mclk, nrst, psel, penable, pwrite, ext_pin, irq, wdt_rst;
    logic pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    int num_errors = 0;
    int n_checks = 0;
    int wait_k;
    tmz_row_t rows[4] = '{'{8'h10, 1'b0}, '{8'hfe, 1'b1}, '{8'hfd, 1'b1},
        '{8'h80, 1'b0}};
    tmz_timer #(.WDT_TICK_DIV(4)) i_dut (.MCLK(mclk), .NRST(nrst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_COUNT_PIN(ext_pin), .IRQ(irq),
        .WDT_RESET(wdt_rst));
    tmz_ext_src i_src (.MCLK(mclk), .EXT_COUNT_PIN(ext_pin));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ****************
    // Bus transfers
    // ****************
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h00_0000, idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            num_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        `CHK(rd, {24'h00_0000, e})
    endtask
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        rdc(8'h81, 8'hff);
        rdc(8'h85, 8'h3f);
        rdc(8'h0b, 8'h00);
        apb(1'b1, 8'h85, 8'h15);
        rdc(8'h85, 8'h15);
        apb(1'b1, 8'h50, 8'hff);
        `CHK(err, 1'b1)
        rdc(8'h50, 8'h00);
        `CHK(err, 1'b1)
        apb(1'b1, 8'h81, 8'h08);
        foreach (rows[i]) begin
            apb(1'b1, 8'h0b, 8'h00);
            apb(1'b1, 8'h01, rows[i].v);
            rdc(8'h01, rows[i].v);
            rdc(8'h01, rows[i].v + 8'h02);
            rdc(8'h0b, {5'h00, rows[i].f, 2'h0});
        end
        apb(1'b1, 8'h81, 8'h07);
        apb(1'b1, 8'h01, 8'h00);
        repeat (200) @(posedge mclk);
        rdc(8'h01, 8'h00);
        repeat (100) @(posedge mclk);
        rdc(8'h01, 8'h01);
        apb(1'b1, 8'h01, 8'h00);
        apb(1'b1, 8'h81, 8'h28);
        apb(1'b1, 8'h01, 8'h00);
        i_src.hold(1'b1, 8);
        rdc(8'h01, 8'h01);
        apb(1'b1, 8'h81, 8'h38);
        i_src.hold(1'b0, 8);
        rdc(8'h01, 8'h02);
        i_src.hold(1'b1, 8);
        rdc(8'h01, 8'h02);
        apb(1'b1, 8'h81, 8'h08);
        apb(1'b1, 8'h92, 8'h01);
        apb(1'b1, 8'h01, 8'h40);
        repeat (20) @(posedge mclk);
        rdc(8'h01, 8'h40);
        apb(1'b1, 8'h92, 8'h00);
        apb(1'b1, 8'h0b, 8'h20);
        apb(1'b1, 8'h91, 8'h01);
        apb(1'b1, 8'h01, 8'hfe);
        repeat (10) @(posedge mclk);
        `CHK(irq, 1'b1)
        apb(1'b1, 8'h91, 8'h00);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h91, 8'h01);
        apb(1'b1, 8'h0b, 8'h04);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h0b, 8'h24);
        `CHK(irq, 1'b1)
        rdc(8'h0b, 8'h24);
        rdc(8'h90, 8'h01);
        apb(1'b1, 8'h90, 8'h01);
        `CHK(irq, 1'b0)
        // Watchdog through the postscaler at 1:1, then its clear
        apb(1'b1, 8'h92, 8'h02);
        wait_k = 0;
        while (wdt_rst !== 1'b1 && wait_k < 1200) begin
            @(negedge mclk);
            wait_k++;
        end
        `CHK(wdt_rst, 1'b1)
        if (wait_k >= 1200) begin
            num_errors++;
            give_verdict();
        end
        @(posedge mclk);
        repeat (40) @(posedge mclk);
        apb(1'b1, 8'h92, 8'h04);
        rdc(8'h93, 8'h00);
        give_verdict();
    end
endmodule
